/* File: pkg/fan_ctrl_map.svh */
`ifndef FAN_CTRL_MAP_SVH
`define FAN_CTRL_MAP_SVH

// Clock and timing
`define CLK_PERIOD_NS 10
`define FAN_COUNT_NS 552500
`define FAN_COUNT_CYCLES ((`FAN_COUNT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EIGHTH_SEC_NS 125000000
`define EIGHTH_SEC_CYCLES (`EIGHTH_SEC_NS / `CLK_PERIOD_NS)
`define PWM_STEPS 7'h64
`define PWM_LAST_STEP 7'h63

// Command and reply types
`define CMD_SET_POWER 8'h11
`define CMD_FAILSAFE 8'h19
`define CMD_GLITCH 8'h1A
`define CMD_QUERY 8'h1B
`define REPLY_FLAG 8'h40
`define REPLY_ERROR 8'hC0
`define LEN_SET_POWER 8'h04
`define LEN_FAILSAFE 8'h02
`define LEN_GLITCH 8'h04
`define LEN_QUERY 8'h00
`define LEN_QUERY_REPLY 8'h05

// Value ranges and defaults
`define LEVEL_FULL 8'h64
`define DELAY_MIN 8'h01
`define DELAY_MAX 8'h64
`define DELAY_DEFAULT 7'h01
`define MASK_VALID 8'h0F

// APB register byte offsets
`define ADDR_CMD 12'h000
`define ADDR_DATA0 12'h004
`define ADDR_DATA1 12'h008
`define ADDR_GO 12'h00C
`define ADDR_REPLY 12'h010
`define ADDR_RDATA0 12'h014
`define ADDR_RDATA1 12'h018
`define ADDR_STATUS 12'h01C
`define ADDR_CTRL 12'h020

// Status and control bit positions
`define ST_REPLY_VALID 0
`define ST_ERROR 1
`define ST_FS_ACTIVE 2
`define ST_BUSY 3
`define ST_FAN_LSB 4
`define CTRL_SAVE_BOOT 0
`define CTRL_LOAD_BOOT 1

`endif

/* File: pkg/fan_ctrl_pkg.sv */
package fan_ctrl_pkg;
   typedef logic [7:0] byte_type;
   typedef logic [6:0] level_type;
   typedef enum logic [0:0] {exec_idle, exec_run} exec_state_type;
endpackage : fan_ctrl_pkg

/* File: rtl/fan_tick_gen.sv */
`timescale 1ns/1ps
`include "fan_ctrl_map.svh"
module fan_tick_gen
   import fan_ctrl_pkg::*;
#(
   parameter int COUNT_CYCLES = `FAN_COUNT_CYCLES,
   parameter int EIGHTH_CYCLES = `EIGHTH_SEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic count_tick,
   output logic eighth_tick,
   output level_type phase
);
   logic [31:0] count_div;
   logic [31:0] eighth_div;

   // Glitch count divider, one hundred per PWM period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_div <= 32'h00000000;
         count_tick <= 1'b0;
      end else if (count_div == 32'(COUNT_CYCLES - 1)) begin
         count_div <= 32'h00000000;
         count_tick <= 1'b1;
      end else begin
         count_div <= count_div + 32'h00000001;
         count_tick <= 1'b0;
      end
   end

   // PWM phase walks 0..99, giving roughly 18 Hz
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 7'h00;
      end else if (count_tick) begin
         phase <= (phase == `PWM_LAST_STEP) ? 7'h00 : phase + 7'h01;
      end
   end

   // Eighth-second ticks for the fail-safe timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eighth_div <= 32'h00000000;
         eighth_tick <= 1'b0;
      end else if (eighth_div == 32'(EIGHTH_CYCLES - 1)) begin
         eighth_div <= 32'h00000000;
         eighth_tick <= 1'b1;
      end else begin
         eighth_div <= eighth_div + 32'h00000001;
         eighth_tick <= 1'b0;
      end
   end
endmodule : fan_tick_gen

/* File: rtl/fan_pwm_channel.sv */
`timescale 1ns/1ps
`include "fan_ctrl_map.svh"
module fan_pwm_channel
   import fan_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic count_tick,
   input level_type phase,
   input level_type level,
   input level_type delay,
   input wire logic tach_in,
   output logic fan_on,
   output logic tach_pulse
);
   logic next_on;
   level_type mask_left;
   logic tach_last;

   // Full on at 100, full off at 0, proportional between
   assign next_on = (phase < level);

   // Supply switched fully on or off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_on <= 1'b0;
      end else begin
         fan_on <= next_on;
      end
   end

   // Blanking window starts at every turn-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_left <= 7'h00;
      end else if (next_on && !fan_on) begin
         mask_left <= delay;
      end else if (count_tick && mask_left != 7'h00) begin
         mask_left <= mask_left - 7'h01;
      end
   end

   // Tach edges only count while powered and unmasked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tach_last <= 1'b0;
         tach_pulse <= 1'b0;
      end else begin
         tach_last <= tach_in;
         tach_pulse <= tach_in && !tach_last && fan_on && mask_left == 7'h00;
      end
   end
endmodule : fan_pwm_channel

/* File: rtl/fan_failsafe_tach_control.sv */
// Function
// - When the fail-safe timeout runs out without a power update, masked fans run at 100%.
// - Fail-safe command 0x19 carries a fan mask (0-15, bit 0 is fan one) and a timeout.
// - The fail-safe timeout byte counts eighth-second ticks, 1 to 255.
// - Fan power is delivered by switching each supply fully on and off.
// - The PWM repeats at about 18 Hz.
// - Tach transitions are ignored for a set number of 552.5 us counts after turn-on.
// - Each fan's glitch delay starts at one count.
// - Glitch command 0x1A carries four delay bytes, 1-100, fans one to four.
// - An accepted glitch command answers with type 0x5A and no payload.
// - Glitch delays are part of the saved power-up configuration.
// - Query command 0x1B has no payload and changes no setting.
// - The query answer is type 0x5B with four fan powers then the fail-safe mask.
// - Set-power command carries four percentages, 0-100, fans one to four.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fan_ctrl_map.svh"
module fan_failsafe_tach_control
   import fan_ctrl_pkg::*;
#(
   parameter int COUNT_CYCLES = `FAN_COUNT_CYCLES,
   parameter int EIGHTH_CYCLES = `EIGHTH_SEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] tach_in,
   output logic [3:0] fan_on,
   output logic [3:0] tach_pulse
);
   // Command staging written by software
   byte_type cmd_type;
   byte_type cmd_len;
   byte_type cmd_data [0:4];
   // Reply returned to software
   byte_type reply_type;
   byte_type reply_len;
   byte_type reply_data [0:4];
   logic reply_valid;
   logic cmd_error;
   // Fan settings
   level_type power [0:3];
   level_type glitch [0:3];
   level_type boot_power [0:3];
   level_type boot_glitch [0:3];
   level_type eff_power [0:3];
   logic [3:0] fs_mask;
   byte_type fs_timeout;
   byte_type fs_count;
   logic fs_active;
   exec_state_type exec_state;
   // Bus decode
   logic bus_access;
   logic bus_write;
   logic bus_read;
   logic addr_ok;
   logic go_write;
   logic save_boot;
   logic load_boot;
   logic reply_read;
   // Command checks
   logic exec_now;
   logic accept_power;
   logic accept_fs;
   logic accept_glitch;
   logic accept_query;
   logic power_update;
   // Timing
   logic count_tick;
   logic eighth_tick;
   level_type phase;

   // Percentage range check
   function automatic logic level_ok(input byte_type v);
      level_ok = (v <= `LEVEL_FULL);
   endfunction : level_ok

   // Glitch delay range check
   function automatic logic delay_ok(input byte_type v);
      delay_ok = (v >= `DELAY_MIN) && (v <= `DELAY_MAX);
   endfunction : delay_ok

   // Known offsets
   function automatic logic mapped(input logic [11:0] a);
      if (a == `ADDR_CMD || a == `ADDR_DATA0 || a == `ADDR_DATA1) begin
         mapped = 1'b1;
      end else if (a == `ADDR_GO || a == `ADDR_REPLY || a == `ADDR_RDATA0) begin
         mapped = 1'b1;
      end else if (a == `ADDR_RDATA1 || a == `ADDR_STATUS || a == `ADDR_CTRL) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   endfunction : mapped

   // Access completes in the first access cycle; the slave inserts no wait state
   assign bus_access = psel && penable && pready;
   assign bus_write = bus_access && pwrite && addr_ok;
   assign bus_read = bus_access && !pwrite && addr_ok;
   assign addr_ok = mapped(paddr);
   assign go_write = bus_write && paddr == `ADDR_GO;
   assign save_boot = bus_write && paddr == `ADDR_CTRL && pwdata[`CTRL_SAVE_BOOT];
   assign load_boot = bus_write && paddr == `ADDR_CTRL && pwdata[`CTRL_LOAD_BOOT];
   assign reply_read = bus_read && paddr == `ADDR_REPLY;

   // Payload validation per command
   assign exec_now = exec_state == exec_run;
   assign accept_power = exec_now && cmd_type == `CMD_SET_POWER && cmd_len == `LEN_SET_POWER
      && level_ok(cmd_data[0]) && level_ok(cmd_data[1])
      && level_ok(cmd_data[2]) && level_ok(cmd_data[3]);
   assign accept_fs = exec_now && cmd_type == `CMD_FAILSAFE && cmd_len == `LEN_FAILSAFE
      && (cmd_data[0] & ~`MASK_VALID) == 8'h00 && cmd_data[1] != 8'h00;
   assign accept_glitch = exec_now && cmd_type == `CMD_GLITCH && cmd_len == `LEN_GLITCH
      && delay_ok(cmd_data[0]) && delay_ok(cmd_data[1])
      && delay_ok(cmd_data[2]) && delay_ok(cmd_data[3]);
   assign accept_query = exec_now && cmd_type == `CMD_QUERY && cmd_len == `LEN_QUERY;
   assign power_update = accept_power || load_boot;

   // APB handshake, no wait state, error on unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready && !mapped(paddr);
      end
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `ADDR_CMD) begin
            prdata <= {16'h0000, cmd_len, cmd_type};
         end else if (paddr == `ADDR_DATA0) begin
            prdata <= {cmd_data[3], cmd_data[2], cmd_data[1], cmd_data[0]};
         end else if (paddr == `ADDR_DATA1) begin
            prdata <= {24'h000000, cmd_data[4]};
         end else if (paddr == `ADDR_REPLY) begin
            prdata <= {16'h0000, reply_len, reply_type};
         end else if (paddr == `ADDR_RDATA0) begin
            prdata <= {reply_data[3], reply_data[2], reply_data[1], reply_data[0]};
         end else if (paddr == `ADDR_RDATA1) begin
            prdata <= {24'h000000, reply_data[4]};
         end else if (paddr == `ADDR_STATUS) begin
            prdata <= {24'h000000, fan_on, exec_now, fs_active, cmd_error, reply_valid};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Command staging registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_type <= 8'h00;
         cmd_len <= 8'h00;
         for (int i = 0; i < 5; i++) begin
            cmd_data[i] <= 8'h00;
         end
      end else if (bus_write && !exec_now) begin
         if (paddr == `ADDR_CMD) begin
            cmd_type <= pwdata[7:0];
            cmd_len <= pwdata[15:8];
         end else if (paddr == `ADDR_DATA0) begin
            cmd_data[0] <= pwdata[7:0];
            cmd_data[1] <= pwdata[15:8];
            cmd_data[2] <= pwdata[23:16];
            cmd_data[3] <= pwdata[31:24];
         end else if (paddr == `ADDR_DATA1) begin
            cmd_data[4] <= pwdata[7:0];
         end
      end
   end

   // One cycle of execution after a go write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_state <= exec_idle;
      end else begin
         case (exec_state)
            exec_idle: begin
               if (go_write) begin
                  exec_state <= exec_run;
               end
            end
            default: begin
               exec_state <= exec_idle;
            end
         endcase
      end
   end

   // Reply build; refused commands answer with the error type
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_type <= 8'h00;
         reply_len <= 8'h00;
         cmd_error <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            reply_data[i] <= 8'h00;
         end
      end else if (exec_now) begin
         for (int i = 0; i < 5; i++) begin
            reply_data[i] <= 8'h00;
         end
         reply_len <= 8'h00;
         if (accept_power || accept_fs || accept_glitch) begin
            reply_type <= cmd_type | `REPLY_FLAG;
            cmd_error <= 1'b0;
         end else if (accept_query) begin
            reply_type <= cmd_type | `REPLY_FLAG;
            reply_len <= `LEN_QUERY_REPLY;
            for (int i = 0; i < 4; i++) begin
               reply_data[i] <= {1'b0, eff_power[i]};
            end
            reply_data[4] <= {4'h0, fs_mask};
            cmd_error <= 1'b0;
         end else begin
            reply_type <= cmd_type | `REPLY_ERROR;
            cmd_error <= 1'b1;
         end
      end
   end

   // Reply flag: a new reply wins over a read of the old one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_valid <= 1'b0;
      end else if (exec_now) begin
         reply_valid <= 1'b1;
      end else if (reply_read) begin
         reply_valid <= 1'b0;
      end
   end

   // Power settings; query leaves them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            power[i] <= 7'h00;
         end
      end else if (accept_power) begin
         for (int i = 0; i < 4; i++) begin
            power[i] <= cmd_data[i][6:0];
         end
      end else if (load_boot) begin
         for (int i = 0; i < 4; i++) begin
            power[i] <= boot_power[i];
         end
      end
   end

   // Glitch delays, default one count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            glitch[i] <= `DELAY_DEFAULT;
         end
      end else if (accept_glitch) begin
         for (int i = 0; i < 4; i++) begin
            glitch[i] <= cmd_data[i][6:0];
         end
      end else if (load_boot) begin
         for (int i = 0; i < 4; i++) begin
            glitch[i] <= boot_glitch[i];
         end
      end
   end

   // Saved power-up state; lost on hard reset, kept over soft reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            boot_power[i] <= 7'h00;
            boot_glitch[i] <= `DELAY_DEFAULT;
         end
      end else if (save_boot) begin
         for (int i = 0; i < 4; i++) begin
            boot_power[i] <= power[i];
            boot_glitch[i] <= glitch[i];
         end
      end
   end

   // Fail-safe mask and timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_mask <= 4'h0;
         fs_timeout <= 8'h00;
      end else if (accept_fs) begin
         fs_mask <= cmd_data[0][3:0];
         fs_timeout <= cmd_data[1];
      end
   end

   // Timeout counter restarts on every power update or re-arm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_count <= 8'h00;
         fs_active <= 1'b0;
      end else if (power_update || accept_fs) begin
         fs_count <= 8'h00;
         fs_active <= 1'b0;
      end else if (eighth_tick && !fs_active && fs_timeout != 8'h00) begin
         if (fs_count + 8'h01 >= fs_timeout) begin
            fs_active <= 1'b1;
         end
         fs_count <= fs_count + 8'h01;
      end
   end

   // Forced full power for masked fans once expired
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         eff_power[i] = (fs_active && fs_mask[i]) ? level_type'(`LEVEL_FULL) : power[i];
      end
   end

   // Shared count and phase timing
   fan_tick_gen #(
      .COUNT_CYCLES(COUNT_CYCLES),
      .EIGHTH_CYCLES(EIGHTH_CYCLES)
   ) u_ticks (
      .pclk(pclk),
      .presetn(presetn),
      .count_tick(count_tick),
      .eighth_tick(eighth_tick),
      .phase(phase)
   );

   // One PWM and tach blanker per fan
   generate
      for (genvar g = 0; g < 4; g++) begin : g_fan
         fan_pwm_channel u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .count_tick(count_tick),
            .phase(phase),
            .level(eff_power[g]),
            .delay(glitch[g]),
            .tach_in(tach_in[g]),
            .fan_on(fan_on[g]),
            .tach_pulse(tach_pulse[g])
         );
      end
   endgenerate
endmodule : fan_failsafe_tach_control

/* File: tb/fan_ctrl_checker.sv */
`timescale 1ns/1ps
module fan_ctrl_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] fan_on,
   input wire logic [3:0] tach_pulse
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Bus timing: one wait-free access cycle per setup
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no pready after setup");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
   property p_idle;
      !psel |=> !pready;
   endproperty
   a_idle: assert property (p_idle) else $error("pready without select");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("pslverr outside access");
   // Reads above 0x020 refused with zero data; mapped words never refused
   property p_unmapped;
      psel && !penable && !pwrite && paddr > 12'h020 |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_mapped;
      psel && !penable && paddr <= 12'h020 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_rd_hold;
      pready && !pwrite |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data lost after access");
   // Tach edges only count while powered, never right after fan 2 turns on
   property p_tach_on;
      (tach_pulse & ~$past(fan_on)) == 4'h0;
   endproperty
   a_tach_on: assert property (p_tach_on) else $error("tach pulse on idle fan");
   property p_tach_mask;
      $rose(fan_on[1]) |-> !tach_pulse[1] [*2];
   endproperty
   a_tach_mask: assert property (p_tach_mask) else $error("tach not masked");
endmodule : fan_ctrl_checker

bind fan_failsafe_tach_control fan_ctrl_checker fan_ctrl_checker_i (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .fan_on(fan_on),
   .tach_pulse(tach_pulse)
);

/* File: tb/fan_tach_model.sv */
`timescale 1ns/1ps
module fan_tach_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] fan_on,
   output logic [3:0] tach_in
);
   logic [1:0] div;

   // Powered fan toggles every third cycle; unpowered output is junk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 2'h0;
         tach_in <= 4'h0;
      end else begin
         div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
         for (int k = 0; k < 4; k++) begin
            if (!fan_on[k] || div == 2'h0) begin
               tach_in[k] <= ~tach_in[k]; // Invalid without power
            end
         end
      end
   end
endmodule : fan_tach_model

/* File: tb/fan_failsafe_tach_control_tb_top.sv */
`timescale 1ns/1ps
`include "fan_ctrl_map.svh"
module fan_failsafe_tach_control_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] tach_in;
   logic [3:0] fan_on;
   logic [3:0] tach_pulse;
   logic [31:0] rd;
   logic er;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int on_cnt [4];
   int pul_cnt [4];
   int rise_cnt;

   // Short counts: one step is 4 cycles, one tick 50 cycles
   fan_failsafe_tach_control #(.COUNT_CYCLES(4), .EIGHTH_CYCLES(50)) fan_failsafe_tach_control_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tach_in(tach_in), .fan_on(fan_on), .tach_pulse(tach_pulse));
   fan_tach_model fan_tach_model_i (
      .pclk(pclk), .presetn(presetn), .fan_on(fan_on), .tach_in(tach_in));

   always #5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   task print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   // Request held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task cmd(input logic [7:0] t, input logic [7:0] n, input logic [31:0] d0,
            input logic [15:0] exp);
      apb(1'b1, `ADDR_CMD, {16'h0, n, t});
      apb(1'b1, `ADDR_DATA0, d0);
      apb(1'b1, `ADDR_GO, 32'h1);
      apb(1'b0, `ADDR_REPLY, 32'h0);
      chk("reply", {16'h0, exp}, rd);
   endtask : cmd

   task query(input logic [31:0] p, input logic [7:0] m);
      cmd(`CMD_QUERY, 8'h00, 32'h0, 16'h055B);
      apb(1'b0, `ADDR_RDATA0, 32'h0);
      chk("powers", p, rd);
      apb(1'b0, `ADDR_RDATA1, 32'h0);
      chk("mask", {24'h0, m}, rd);
   endtask : query

   // Sampled mid-cycle, away from the launching edge
   task measure(input int n);
      logic prev;
      on_cnt = '{0, 0, 0, 0};
      pul_cnt = '{0, 0, 0, 0};
      rise_cnt = 0;
      prev = fan_on[0];
      repeat (n) begin
         @(negedge pclk);
         rise_cnt += (fan_on[0] === 1'b1 && prev === 1'b0);
         prev = fan_on[0];
         for (int k = 0; k < 4; k++) begin
            on_cnt[k] += (fan_on[k] === 1'b1);
            pul_cnt[k] += (tach_pulse[k] === 1'b1);
         end
      end
   endtask : measure

   task t_reset;
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      apb(1'b0, 12'h040, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      query(32'h0, 8'h00);
   endtask : t_reset

   // Host arms fans 1 and 2, then goes silent
   task t_failsafe;
      int t0;
      cmd(`CMD_FAILSAFE, 8'h02, 32'h0000_0203, 16'h0059);
      t0 = cyc;
      for (int i = 0; i < 60; i++) begin
         apb(1'b0, `ADDR_STATUS, 32'h0);
         if (rd[`ST_FS_ACTIVE] === 1'b1) break;
      end
      chk("fs time", 32'h1, (cyc - t0 >= 40 && cyc - t0 <= 130));
      measure(20);
      chk("forced1", 32'd20, on_cnt[0]);
      chk("forced2", 32'd20, on_cnt[1]);
      chk("free3", 32'd0, on_cnt[2]);
      query(32'h0000_6464, 8'h03);
      query(32'h0000_6464, 8'h03);
   endtask : t_failsafe

   // One window of 400 cycles is exactly one period of 100 steps
   task t_power;
      cmd(`CMD_SET_POWER, 8'h04, 32'h1900_6432, 16'h0051);
      measure(400);
      chk("duty1", 32'd200, on_cnt[0]);
      chk("duty2", 32'd400, on_cnt[1]);
      chk("duty3", 32'd0, on_cnt[2]);
      chk("duty4", 32'd100, on_cnt[3]);
      chk("period", 32'd1, rise_cnt);
      chk("tach1", 32'h1, pul_cnt[0] > 0);
      chk("tach3", 32'd0, pul_cnt[2]);
      query(32'h1900_6432, 8'h00);
   endtask : t_power

   // Long blanking hides the whole on-time of fan 1; first window lets it reload
   task t_glitch;
      cmd(`CMD_GLITCH, 8'h04, 32'h0101_0164, 16'h005A);
      measure(400);
      measure(400);
      chk("blank1", 32'd0, pul_cnt[0]);
      chk("tach2", 32'h1, pul_cnt[1] > 0);
      apb(1'b1, `ADDR_CTRL, 32'h1);
      cmd(`CMD_GLITCH, 8'h04, 32'h0101_0100, 16'h00DA);
      cmd(`CMD_SET_POWER, 8'h04, 32'h0000_0065, 16'h00D1);
      cmd(`CMD_FAILSAFE, 8'h02, 32'h0000_0210, 16'h00D9);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("err", 32'h1, rd[`ST_ERROR]);
      measure(400);
      chk("kept1", 32'd0, pul_cnt[0]);
      chk("kept2", 32'd200, on_cnt[0]);
      cmd(`CMD_GLITCH, 8'h04, 32'h0101_0101, 16'h005A);
      cmd(`CMD_SET_POWER, 8'h04, 32'h0, 16'h0051);
      apb(1'b1, `ADDR_CTRL, 32'h2);
      measure(400);
      measure(400);
      chk("boot1", 32'd0, pul_cnt[0]);
      query(32'h1900_6432, 8'h00);
   endtask : t_glitch

   // Reset for 8 cycles, and again mid-run so the fail-safe starts clean
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_power;
      t_glitch;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_failsafe;
      print_verdict();
   end
endmodule : fan_failsafe_tach_control_tb_top
